/* rtl/fbs_alu.sv */
// fbs_alu: eight-function four-bit operator with lookahead terms.
// assumes operands are already selected; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fbs_alu #(
  parameter int W = fbs_pkg::FBS_WIDTH
) (
  input wire logic [W-1:0] r,
  input wire logic [W-1:0] s,
  input wire logic cin,
  input wire logic [2:0] func,
  output logic [W-1:0] f,
  output logic cout,
  output logic gen,
  output logic prop,
  output logic ovf
);

  logic [W-1:0] a;
  logic [W-1:0] b;
  logic [W-1:0] g;
  logic [W-1:0] p;
  logic [W:0] c;
  logic arith;

  // operand conditioning: subtraction is addition of the complement
  always_comb begin
    a = r;
    b = s;
    arith = 1'b1;
    case (func)
      fbs_pkg::FBS_FN_ADD: begin
        a = r;
      end
      fbs_pkg::FBS_FN_SUBR: begin
        a = ~r;
      end
      fbs_pkg::FBS_FN_SUBS: begin
        b = ~s;
      end
      default: begin
        arith = 1'b0;
      end
    endcase
  end

  // carry chain; generate/propagate let an external lookahead unit skip it
  always_comb begin
    g = a & b;
    p = a | b;
    c[0] = cin;
    for (int i = 0; i < W; i++) begin
      c[i+1] = g[i] | (p[i] & c[i]);
    end
    gen = 1'b0;
    prop = 1'b1;
    for (int i = 0; i < W; i++) begin
      gen = g[i] | (p[i] & gen);
      prop = prop & p[i];
    end
    // logic functions offer no lookahead terms; kept here so one process drives them
    if (!arith) begin
      gen = 1'b0;
      prop = 1'b0;
    end
  end

  // result and status; logic functions report no carry and no overflow
  always_comb begin
    case (func)
      fbs_pkg::FBS_FN_OR: f = r | s;
      fbs_pkg::FBS_FN_AND: f = r & s;
      fbs_pkg::FBS_FN_NOTRS: f = ~r & s;
      fbs_pkg::FBS_FN_XOR: f = r ^ s;
      fbs_pkg::FBS_FN_XNOR: f = ~(r ^ s);
      default: f = a ^ b ^ c[W-1:0];
    endcase
    cout = arith & c[W];
    ovf = arith & (c[W-1] ^ c[W]);
  end

endmodule : fbs_alu
`default_nettype wire

/* rtl/fbs_pkg.sv */
// fbs_pkg: shared constants and types of the four-bit arithmetic slice.
// assumes every slice and the microprogram controller share one clock.
package fbs_pkg;

  // datapath geometry
  localparam int FBS_WIDTH = 4;
  localparam int FBS_DEPTH = 16;
  localparam int FBS_ADDR_W = 4;
  localparam int FBS_CODE_W = 3;
  localparam int FBS_MSB = 3;
  localparam int FBS_LSB = 0;

  // reset contents of the auxiliary register, result register and file; all-zero operand word
  localparam logic [3:0] FBS_AUX_RESET = 4'h0;
  localparam logic [3:0] FBS_Y_RESET = 4'h0;
  localparam logic [3:0] FBS_WORD_RESET = 4'h0;
  localparam logic [3:0] FBS_ZERO_WORD = 4'h0;

  // clock figures
  localparam int FBS_CLK_PERIOD_NS = 50;

  // operand source codes
  localparam logic [2:0] FBS_SRC_A_AUX = 3'h0;
  localparam logic [2:0] FBS_SRC_A_B = 3'h1;
  localparam logic [2:0] FBS_SRC_Z_AUX = 3'h2;
  localparam logic [2:0] FBS_SRC_Z_B = 3'h3;
  localparam logic [2:0] FBS_SRC_Z_A = 3'h4;
  localparam logic [2:0] FBS_SRC_D_A = 3'h5;
  localparam logic [2:0] FBS_SRC_D_AUX = 3'h6;
  localparam logic [2:0] FBS_SRC_D_Z = 3'h7;

  // function codes
  localparam logic [2:0] FBS_FN_ADD = 3'h0;
  localparam logic [2:0] FBS_FN_SUBR = 3'h1;
  localparam logic [2:0] FBS_FN_SUBS = 3'h2;
  localparam logic [2:0] FBS_FN_OR = 3'h3;
  localparam logic [2:0] FBS_FN_AND = 3'h4;
  localparam logic [2:0] FBS_FN_NOTRS = 3'h5;
  localparam logic [2:0] FBS_FN_XOR = 3'h6;
  localparam logic [2:0] FBS_FN_XNOR = 3'h7;

  // destination codes
  localparam logic [2:0] FBS_DST_AUXLD = 3'h0;
  localparam logic [2:0] FBS_DST_NOP = 3'h1;
  localparam logic [2:0] FBS_DST_WR_A = 3'h2;
  localparam logic [2:0] FBS_DST_WR_F = 3'h3;
  localparam logic [2:0] FBS_DST_DN_AUX = 3'h4;
  localparam logic [2:0] FBS_DST_DN = 3'h5;
  localparam logic [2:0] FBS_DST_UP_AUX = 3'h6;
  localparam logic [2:0] FBS_DST_UP = 3'h7;

  typedef enum {FBS_R_PORTA, FBS_R_ZERO, FBS_R_DIRECT} fbs_rsel_t;
  typedef enum {FBS_S_PORTA, FBS_S_PORTB, FBS_S_AUX, FBS_S_ZERO} fbs_ssel_t;
  typedef enum {FBS_SH_NONE, FBS_SH_DOWN, FBS_SH_UP} fbs_shift_t;

endpackage : fbs_pkg

/* rtl/fbs_regfile.sv */
// fbs_regfile: sixteen-word two-port working file with combinational reads.
// assumes the write is a single clock edge at the end of the microcycle.
`timescale 1ns/1ps
`default_nettype none
module fbs_regfile #(
  parameter int W = fbs_pkg::FBS_WIDTH,
  parameter int DEPTH = fbs_pkg::FBS_DEPTH,
  parameter int AW = fbs_pkg::FBS_ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] addr_a,
  input wire logic [AW-1:0] addr_b,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_a,
  output logic [W-1:0] rd_b
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] word;
  } fbs_file_state_t;

  fbs_file_state_t st;
  fbs_file_state_t next_st;

  // equal addresses, same word
  // both ports read the stored words at once; equal addresses give one word
  always_comb begin
    rd_a = st.word[addr_a];
    rd_b = st.word[addr_b];
  end

  // only the second address is ever written; the write lands on the edge,
  // so the operands seen during the cycle are the pre-write words and no
  // race between reading and writing can arise
  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.word[addr_b] = wr_data;
    end
  end

  // file storage, cleared by reset so simulation starts defined
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '{word: {DEPTH{fbs_pkg::FBS_WORD_RESET}}};
    end else begin
      st <= next_st;
    end
  end

endmodule : fbs_regfile
`default_nettype wire

/* rtl/fbs_slice_top.sv */
// fbs_slice_top: cascadable four-bit arithmetic slice, one microcycle per clock.
// assumes the controller and neighbouring slices run on REF_CLK, so the
// shift pins and carry are same-domain signals and are not synchronised.
//
// How it works
// - sixteen four-bit words, two independent read ports
// - equal addresses show identical word on both
// - writes go only to second address
// - file input unshifted, shifted up or down
// - write lands on the edge so reads cannot be disturbed
// - first operand: port A or direct input
// - second operand: port A, port B, aux
// - inhibit setting gives an all-zero operand
// - operand-select code maps the eight pairs
// - three arithmetic, five logic functions selected
// - function code map; carry adds one
// - carry in and out active high
// - generate, propagate and ripple carry out
// - sign is top result bit, always valid
// - zero high when result all low, open-collector
// - overflow when top two carries differ
// - destination code picks store and output
// - destination code map incl. aux shifts
// - aux loads on edge, file writes
// - result output high impedance when disabled
// - separate four-bit auxiliary register
`timescale 1ns/1ps
`default_nettype none
module fbs_slice_top #(
  parameter int W = fbs_pkg::FBS_WIDTH,
  parameter int AW = fbs_pkg::FBS_ADDR_W
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [AW-1:0] ADDR_A,
  input wire logic [AW-1:0] ADDR_B,
  input wire logic [W-1:0] DIRECT_IN,
  input wire logic [2:0] SRC_SEL,
  input wire logic [2:0] FUNC_SEL,
  input wire logic [2:0] DEST_SEL,
  input wire logic CARRY_IN,
  input wire logic OE_N,
  output logic [W-1:0] Y_OUT,
  output logic Y_OE,
  output logic CARRY_OUT,
  output logic CARRY_GEN,
  output logic CARRY_PROP,
  output logic OVERFLOW_FLAG,
  output logic SIGN_OUT,
  output logic ZERO_OUT,
  output logic ZERO_OE,
  input wire logic FILE_LO_IN,
  output logic FILE_LO_OUT,
  output logic FILE_LO_OE,
  input wire logic FILE_HI_IN,
  output logic FILE_HI_OUT,
  output logic FILE_HI_OE,
  input wire logic AUX_LO_IN,
  output logic AUX_LO_OUT,
  output logic AUX_LO_OE,
  input wire logic AUX_HI_IN,
  output logic AUX_HI_OUT,
  output logic AUX_HI_OE
);

  // decoded destination control
  typedef struct packed {
    logic aux_load;
    logic file_wr;
    logic y_from_a;
    logic aux_shift;
    logic aux_pins;
  } fbs_dest_t;

  // all state of this module: auxiliary register and registered result
  typedef struct packed {
    logic [W-1:0] aux;
    logic [W-1:0] y;
  } fbs_top_state_t;

  fbs_top_state_t st;
  fbs_top_state_t next_st;

  logic [W-1:0] port_a;
  logic [W-1:0] port_b;
  logic [W-1:0] op_r;
  logic [W-1:0] op_s;
  logic [W-1:0] alu_f;
  logic [W-1:0] file_din;
  logic alu_cout;
  logic alu_gen;
  logic alu_prop;
  logic alu_ovf;
  fbs_pkg::fbs_rsel_t rsel;
  fbs_pkg::fbs_ssel_t ssel;
  fbs_pkg::fbs_shift_t shift;
  fbs_dest_t dest;

  // first operand source for a source code
  function automatic fbs_pkg::fbs_rsel_t fbs_decode_r(input logic [2:0] code);
    fbs_pkg::fbs_rsel_t sel;
    case (code)
      fbs_pkg::FBS_SRC_A_AUX: sel = fbs_pkg::FBS_R_PORTA;
      fbs_pkg::FBS_SRC_A_B: sel = fbs_pkg::FBS_R_PORTA;
      fbs_pkg::FBS_SRC_Z_AUX: sel = fbs_pkg::FBS_R_ZERO;
      fbs_pkg::FBS_SRC_Z_B: sel = fbs_pkg::FBS_R_ZERO;
      fbs_pkg::FBS_SRC_Z_A: sel = fbs_pkg::FBS_R_ZERO;
      default: sel = fbs_pkg::FBS_R_DIRECT;
    endcase
    return sel;
  endfunction : fbs_decode_r

  // second operand source for a source code
  function automatic fbs_pkg::fbs_ssel_t fbs_decode_s(input logic [2:0] code);
    fbs_pkg::fbs_ssel_t sel;
    case (code)
      fbs_pkg::FBS_SRC_A_AUX: sel = fbs_pkg::FBS_S_AUX;
      fbs_pkg::FBS_SRC_A_B: sel = fbs_pkg::FBS_S_PORTB;
      fbs_pkg::FBS_SRC_Z_AUX: sel = fbs_pkg::FBS_S_AUX;
      fbs_pkg::FBS_SRC_Z_B: sel = fbs_pkg::FBS_S_PORTB;
      fbs_pkg::FBS_SRC_Z_A: sel = fbs_pkg::FBS_S_PORTA;
      fbs_pkg::FBS_SRC_D_A: sel = fbs_pkg::FBS_S_PORTA;
      fbs_pkg::FBS_SRC_D_AUX: sel = fbs_pkg::FBS_S_AUX;
      default: sel = fbs_pkg::FBS_S_ZERO;
    endcase
    return sel;
  endfunction : fbs_decode_s

  // file shift direction for a destination code
  function automatic fbs_pkg::fbs_shift_t fbs_decode_shift(input logic [2:0] code);
    fbs_pkg::fbs_shift_t sh;
    case (code)
      fbs_pkg::FBS_DST_DN_AUX: sh = fbs_pkg::FBS_SH_DOWN;
      fbs_pkg::FBS_DST_DN: sh = fbs_pkg::FBS_SH_DOWN;
      fbs_pkg::FBS_DST_UP_AUX: sh = fbs_pkg::FBS_SH_UP;
      fbs_pkg::FBS_DST_UP: sh = fbs_pkg::FBS_SH_UP;
      default: sh = fbs_pkg::FBS_SH_NONE;
    endcase
    return sh;
  endfunction : fbs_decode_shift

  // storage and output controls for a destination code
  function automatic fbs_dest_t fbs_decode_dest(input logic [2:0] code);
    fbs_dest_t d;
    d = '0;
    case (code)
      fbs_pkg::FBS_DST_AUXLD: begin
        d.aux_load = 1'b1;
      end
      fbs_pkg::FBS_DST_NOP: begin
        d.aux_load = 1'b0;
      end
      fbs_pkg::FBS_DST_WR_A: begin
        d.file_wr = 1'b1;
        d.y_from_a = 1'b1;
      end
      fbs_pkg::FBS_DST_WR_F: begin
        d.file_wr = 1'b1;
      end
      fbs_pkg::FBS_DST_DN_AUX, fbs_pkg::FBS_DST_UP_AUX: begin
        d.file_wr = 1'b1;
        d.aux_shift = 1'b1;
        d.aux_pins = 1'b1;
      end
      fbs_pkg::FBS_DST_DN: begin
        d.file_wr = 1'b1;
        d.aux_pins = 1'b1;
      end
      default: begin
        d.file_wr = 1'b1;
      end
    endcase
    return d;
  endfunction : fbs_decode_dest

  // shift a word one place, filling the vacated end from a neighbour pin
  function automatic logic [W-1:0] fbs_shift_word(input logic [W-1:0] word,
                                                  input fbs_pkg::fbs_shift_t sh,
                                                  input logic fill_lo,
                                                  input logic fill_hi);
    logic [W-1:0] res;
    case (sh)
      fbs_pkg::FBS_SH_DOWN: res = {fill_hi, word[W-1:1]};
      fbs_pkg::FBS_SH_UP: res = {word[W-2:0], fill_lo};
      default: res = word;
    endcase
    return res;
  endfunction : fbs_shift_word

  // controller picks codes
  // the microinstruction is decoded fresh every cycle; no code is held here
  always_comb begin
    rsel = fbs_decode_r(SRC_SEL);
    ssel = fbs_decode_s(SRC_SEL);
    shift = fbs_decode_shift(DEST_SEL);
    dest = fbs_decode_dest(DEST_SEL);
  end

  fbs_regfile #(
    .W(W),
    .DEPTH(fbs_pkg::FBS_DEPTH),
    .AW(AW)
  ) u_file (
    .clk(REF_CLK),
    .rstn(RSTN),
    .addr_a(ADDR_A),
    .addr_b(ADDR_B),
    .wr_en(dest.file_wr),
    .wr_data(file_din),
    .rd_a(port_a),
    .rd_b(port_b)
  );

  always_comb begin
    case (rsel)
      fbs_pkg::FBS_R_PORTA: op_r = port_a;
      fbs_pkg::FBS_R_DIRECT: op_r = DIRECT_IN;
      default: op_r = fbs_pkg::FBS_ZERO_WORD;
    endcase
  end

  always_comb begin
    case (ssel)
      fbs_pkg::FBS_S_PORTA: op_s = port_a;
      fbs_pkg::FBS_S_PORTB: op_s = port_b;
      fbs_pkg::FBS_S_AUX: op_s = st.aux;
      default: op_s = fbs_pkg::FBS_ZERO_WORD;
    endcase
  end

  fbs_alu #(
    .W(W)
  ) u_alu (
    .r(op_r),
    .s(op_s),
    .cin(CARRY_IN),
    .func(FUNC_SEL),
    .f(alu_f),
    .cout(alu_cout),
    .gen(alu_gen),
    .prop(alu_prop),
    .ovf(alu_ovf)
  );

  // file input shifter
  // the vacated bit comes from the neighbouring slice in the same cycle
  always_comb begin
    file_din = fbs_shift_word(alu_f, shift, FILE_LO_IN, FILE_HI_IN);
  end

  // overflow from carries
  // combinational so ripple and lookahead chains settle within one cycle
  always_comb begin
    CARRY_OUT = alu_cout;
    CARRY_GEN = alu_gen;
    CARRY_PROP = alu_prop;
    OVERFLOW_FLAG = alu_ovf;
  end

  // open-collector zero detect
  // the pin is only ever pulled low, so slices can share one wire
  always_comb begin
    SIGN_OUT = alu_f[fbs_pkg::FBS_MSB];
    ZERO_OUT = 1'b0;
    ZERO_OE = (alu_f != fbs_pkg::FBS_ZERO_WORD);
  end

  // file shift pins
  // outgoing end bit driven only in the matching direction
  always_comb begin
    FILE_LO_OUT = alu_f[fbs_pkg::FBS_LSB];
    FILE_HI_OUT = alu_f[fbs_pkg::FBS_MSB];
    FILE_LO_OE = (shift == fbs_pkg::FBS_SH_DOWN);
    FILE_HI_OE = (shift == fbs_pkg::FBS_SH_UP);
  end

  // aux shift pins
  // code 5 still drives the low aux bit; code 7 leaves both released
  always_comb begin
    AUX_LO_OUT = st.aux[fbs_pkg::FBS_LSB];
    AUX_HI_OUT = st.aux[fbs_pkg::FBS_MSB];
    AUX_LO_OE = dest.aux_pins && (shift == fbs_pkg::FBS_SH_DOWN);
    AUX_HI_OE = dest.aux_pins && (shift == fbs_pkg::FBS_SH_UP);
  end

  always_comb begin
    next_st = st;
    if (dest.aux_load) begin
      next_st.aux = alu_f;
    end else if (dest.aux_shift) begin
      next_st.aux = fbs_shift_word(st.aux, shift, AUX_LO_IN, AUX_HI_IN);
    end
    next_st.y = dest.y_from_a ? port_a : alu_f;
  end

  // aux loads on edge
  // a single edge ends the microcycle for the file, aux and result alike
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      st <= '{aux: fbs_pkg::FBS_AUX_RESET, y: fbs_pkg::FBS_Y_RESET};
    end else begin
      st <= next_st;
    end
  end

  // result output enable
  // data comes from the register; the enable follows the pin at once
  always_comb begin
    Y_OUT = st.y;
    Y_OE = !OE_N;
  end

endmodule : fbs_slice_top
`default_nettype wire

/* verif/fbs_neighbour.sv */
// fbs_neighbour: the neighbouring slices at the four shift pins.
// assumes pins are ordered file lo, file hi, aux lo, aux hi.
`timescale 1ns/1ps
`default_nettype none
module fbs_neighbour (
  input wire logic clk,
  input wire logic [2:0] dest,
  input wire logic [3:0] nb,
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  output logic [3:0] lvl
);
  logic [3:0] drv;
  logic [3:0] last = 4'h0;
  assign drv = {2{dest[2] & ~dest[1], dest[2] & dest[1]}};
  // released pin shows no stale level
  assign lvl = (oe & out) | (~oe & drv & nb) | (~oe & ~drv & ~last);
  // remember the level so a floating pin keeps toggling
  always_ff @(posedge clk) begin
    last <= lvl;
  end
endmodule : fbs_neighbour
`default_nettype wire

/* verif/fbs_slice_top_assertions.sv */
// fbs_slice_top_assertions: port properties of the slice.
// assumes one clock domain; bound onto fbs_slice_top.
`timescale 1ns/1ps
`default_nettype none
module fbs_slice_top_assertions #(
  parameter int W = fbs_pkg::FBS_WIDTH
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [W-1:0] DIRECT_IN,
  input wire logic [2:0] SRC_SEL,
  input wire logic [2:0] FUNC_SEL,
  input wire logic [2:0] DEST_SEL,
  input wire logic CARRY_IN,
  input wire logic OE_N,
  input wire logic [W-1:0] Y_OUT,
  input wire logic Y_OE,
  input wire logic CARRY_OUT,
  input wire logic OVERFLOW_FLAG,
  input wire logic SIGN_OUT,
  input wire logic ZERO_OUT,
  input wire logic ZERO_OE,
  input wire logic FILE_LO_OUT,
  input wire logic FILE_LO_OE,
  input wire logic FILE_HI_OUT,
  input wire logic FILE_HI_OE,
  input wire logic AUX_LO_IN,
  input wire logic AUX_LO_OUT,
  input wire logic AUX_LO_OE,
  input wire logic AUX_HI_IN,
  input wire logic AUX_HI_OUT,
  input wire logic AUX_HI_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // sign is the stored top bit
  a_sign_to_y: assert property ((DEST_SEL != 3'h2) |=> Y_OUT[W-1] == $past(SIGN_OUT))
    else $error("sign output disagrees with stored result");
  a_zero_detect: assert property ((DEST_SEL != 3'h2) |=> ((~|Y_OUT) != $past(ZERO_OE)) && !ZERO_OUT)
    else $error("zero detect disagrees with stored result");
  a_y_release: assert property (Y_OE != OE_N)
    else $error("result enable does not follow disable input");
  a_file_shift_en: assert property (FILE_LO_OE == (DEST_SEL[2:1] == 2'b10) && FILE_HI_OE == (DEST_SEL[2:1] == 2'b11))
    else $error("file shift pin enable wrong");
  a_aux_shift_en: assert property (AUX_LO_OE == (DEST_SEL[2:1] == 2'b10) && AUX_HI_OE == (DEST_SEL == 3'h6))
    else $error("aux shift pin enable wrong");
  // low end leaves on down shift
  a_low_bit_out: assert property (FILE_LO_OE |=> Y_OUT[0] == $past(FILE_LO_OUT))
    else $error("file low pin is not the result low bit");
  // high end leaves on up shift
  a_high_bit_out: assert property (FILE_HI_OE |-> FILE_HI_OUT == SIGN_OUT)
    else $error("file high pin is not the result top bit");
  a_aux_down: assert property ((DEST_SEL == 3'h4) |=> AUX_HI_OUT == $past(AUX_HI_IN))
    else $error("aux down shift lost the incoming bit");
  a_aux_up: assert property ((DEST_SEL == 3'h6) |=> AUX_LO_OUT == $past(AUX_LO_IN))
    else $error("aux up shift lost the incoming bit");
  a_carry_direct: assert property ((SRC_SEL == 3'h7 && FUNC_SEL == 3'h0) |-> CARRY_OUT == (&DIRECT_IN && CARRY_IN))
    else $error("carry out wrong for direct plus carry");
  a_logic_flags: assert property ((FUNC_SEL >= 3'h3) |-> !CARRY_OUT && !OVERFLOW_FLAG)
    else $error("logic function raised carry or overflow");
  c_down: cover property (DEST_SEL == 3'h4);
  c_up: cover property (DEST_SEL == 3'h6);
  c_carry: cover property (CARRY_OUT && OVERFLOW_FLAG == 1'b0);
endmodule : fbs_slice_top_assertions
bind fbs_slice_top fbs_slice_top_assertions #(.W(W)) u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .DIRECT_IN(DIRECT_IN), .SRC_SEL(SRC_SEL),
  .FUNC_SEL(FUNC_SEL), .DEST_SEL(DEST_SEL), .CARRY_IN(CARRY_IN), .OE_N(OE_N),
  .Y_OUT(Y_OUT), .Y_OE(Y_OE), .CARRY_OUT(CARRY_OUT), .OVERFLOW_FLAG(OVERFLOW_FLAG),
  .SIGN_OUT(SIGN_OUT), .ZERO_OUT(ZERO_OUT), .ZERO_OE(ZERO_OE),
  .FILE_LO_OUT(FILE_LO_OUT), .FILE_LO_OE(FILE_LO_OE), .FILE_HI_OUT(FILE_HI_OUT),
  .FILE_HI_OE(FILE_HI_OE), .AUX_LO_IN(AUX_LO_IN), .AUX_LO_OUT(AUX_LO_OUT),
  .AUX_LO_OE(AUX_LO_OE), .AUX_HI_IN(AUX_HI_IN), .AUX_HI_OUT(AUX_HI_OUT),
  .AUX_HI_OE(AUX_HI_OE)
);
`default_nettype wire

/* verif/fbs_slice_top_bench.sv */
// fbs_slice_top_bench: self-checking bench for the four-bit slice.
// assumes a 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module fbs_slice_top_bench;
  typedef struct packed {
    logic [2:0] s;
    logic [2:0] fn;
    logic c;
    logic [3:0] d;
    logic [3:0] f;
    logic co;
    logic ov;
  } fbs_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] a = 4'h0, b = 4'h0, d = 4'h0, nb = 4'h0, nbn = 4'h0;
  logic [2:0] src = 3'h0, fn = 3'h0, dst = 3'h0;
  logic cin = 1'b0, oe_n = 1'b0, oen = 1'b0;
  logic [3:0] y, lvl;
  logic y_oe, co, cg, cp, ov, sg, zo, zoe;
  wire logic [3:0] po, pe;
  wire logic zero_wire = zoe ? zo : 1'b1;
  int n_errors = 0;
  int num_checks = 0;
  // word1=6 word2=3 aux=5; rows use first port 1, second port 2
  fbs_row_t rows [11] = '{
    '{3'h0, 3'h0, 1'b1, 4'h9, 4'hc, 1'b0, 1'b1}, '{3'h1, 3'h1, 1'b1, 4'h9, 4'hd, 1'b0, 1'b0},
    '{3'h2, 3'h2, 1'b1, 4'h9, 4'hb, 1'b0, 1'b0}, '{3'h3, 3'h3, 1'b0, 4'h9, 4'h3, 1'b0, 1'b0},
    '{3'h4, 3'h4, 1'b0, 4'h9, 4'h0, 1'b0, 1'b0}, '{3'h5, 3'h5, 1'b0, 4'h9, 4'h6, 1'b0, 1'b0},
    '{3'h6, 3'h6, 1'b0, 4'h9, 4'hc, 1'b0, 1'b0}, '{3'h7, 3'h7, 1'b0, 4'h9, 4'h6, 1'b0, 1'b0},
    '{3'h6, 3'h0, 1'b1, 4'hf, 4'h5, 1'b1, 1'b0}, '{3'h7, 3'h0, 1'b1, 4'h7, 4'h8, 1'b0, 1'b1},
    '{3'h7, 3'h0, 1'b1, 4'hf, 4'h0, 1'b1, 1'b0}
  };
  fbs_slice_top dut (
    .REF_CLK(clk), .RSTN(rstn), .ADDR_A(a), .ADDR_B(b), .DIRECT_IN(d), .SRC_SEL(src),
    .FUNC_SEL(fn), .DEST_SEL(dst), .CARRY_IN(cin), .OE_N(oe_n), .Y_OUT(y), .Y_OE(y_oe),
    .CARRY_OUT(co), .CARRY_GEN(cg), .CARRY_PROP(cp), .OVERFLOW_FLAG(ov), .SIGN_OUT(sg),
    .ZERO_OUT(zo), .ZERO_OE(zoe), .FILE_LO_IN(lvl[0]), .FILE_LO_OUT(po[0]),
    .FILE_LO_OE(pe[0]), .FILE_HI_IN(lvl[1]), .FILE_HI_OUT(po[1]), .FILE_HI_OE(pe[1]),
    .AUX_LO_IN(lvl[2]), .AUX_LO_OUT(po[2]), .AUX_LO_OE(pe[2]), .AUX_HI_IN(lvl[3]),
    .AUX_HI_OUT(po[3]), .AUX_HI_OE(pe[3])
  );
  fbs_neighbour nbr (.clk(clk), .dest(dst), .nb(nb), .oe(pe), .out(po), .lvl(lvl));
  // free-running clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one controller word per cycle, settled before the edge
  task automatic op(input logic [2:0] s, input logic [2:0] f, input logic [2:0] ds,
      input logic [3:0] aa, input logic [3:0] bb, input logic [3:0] dd, input logic c);
    @(negedge clk);
    src = s;
    fn = f;
    dst = ds;
    a = aa;
    b = bb;
    d = dd;
    cin = c;
    nb = nbn;
    oe_n = oen;
    #20;
  endtask : op
  task automatic idle();
    op(3'h7, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
  endtask : idle
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // watchdog: the run needs well under 200 cycles
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    #20;
    chk({4'h0, y}, {4'h0, fbs_pkg::FBS_Y_RESET});
    op(3'h7, 3'h0, 3'h3, 4'h0, 4'h1, 4'h6, 1'b0);
    op(3'h7, 3'h0, 3'h3, 4'h0, 4'h2, 4'h3, 1'b0);
    op(3'h7, 3'h0, 3'h0, 4'h0, 4'h0, 4'h5, 1'b0);
    foreach (rows[i]) begin
      op(rows[i].s, rows[i].fn, 3'h1, 4'h1, 4'h2, rows[i].d, rows[i].c);
      chk({4'h0, co, ov, sg, zero_wire}, {4'h0, rows[i].co, rows[i].ov, rows[i].f[3],
          rows[i].f == 4'h0});
      idle();
      chk({4'h0, y}, {4'h0, rows[i].f});
    end
    op(3'h6, 3'h0, 3'h1, 4'h1, 4'h2, 4'hf, 1'b1);
    chk({6'h0, cg, cp}, 8'h03);
    idle();
    chk({6'h0, cg, cp}, 8'h00);
    op(3'h1, 3'h6, 3'h1, 4'h1, 4'h1, 4'h0, 1'b0);
    chk({7'h0, zero_wire}, 8'h01);
    op(3'h7, 3'h0, 3'h3, 4'h1, 4'h4, 4'he, 1'b0);
    op(3'h1, 3'h0, 3'h1, 4'h1, 4'h4, 4'h0, 1'b0);
    idle();
    chk({4'h0, y}, 8'h04);
    // increments back to back must see the fresh word
    op(3'h3, 3'h0, 3'h3, 4'h0, 4'h4, 4'h0, 1'b1);
    op(3'h3, 3'h0, 3'h3, 4'h0, 4'h4, 4'h0, 1'b1);
    chk({3'h0, co, y}, 8'h1f);
    idle();
    chk({4'h0, y}, 8'h00);
    op(3'h7, 3'h0, 3'h2, 4'h1, 4'h6, 4'h9, 1'b0);
    op(3'h4, 3'h3, 3'h1, 4'h6, 4'h0, 4'h0, 1'b0);
    chk({4'h0, y}, 8'h06);
    idle();
    chk({4'h0, y}, 8'h09);
    // file shifts, neighbours feeding a one
    nbn = 4'h2;
    op(3'h7, 3'h3, 3'h5, 4'h0, 4'h7, 4'h6, 1'b0);
    chk({5'h0, pe[1], pe[0], po[0]}, 8'h02);
    nbn = 4'h1;
    op(3'h7, 3'h3, 3'h7, 4'h0, 4'h8, 4'h6, 1'b0);
    chk({5'h0, pe[0], pe[1], po[1]}, 8'h02);
    op(3'h4, 3'h3, 3'h1, 4'h7, 4'h0, 4'h0, 1'b0);
    op(3'h4, 3'h3, 3'h1, 4'h8, 4'h0, 4'h0, 1'b0);
    chk({4'h0, y}, 8'h0b);
    idle();
    chk({4'h0, y}, 8'h0d);
    // aux shifts down then up
    nbn = 4'h8;
    op(3'h7, 3'h3, 3'h4, 4'h0, 4'h9, 4'h6, 1'b0);
    chk({6'h0, pe[2], po[2]}, 8'h03);
    nbn = 4'h0;
    op(3'h7, 3'h3, 3'h6, 4'h0, 4'h9, 4'h6, 1'b0);
    chk({6'h0, pe[3], po[3]}, 8'h03);
    op(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
    idle();
    chk({4'h0, y}, 8'h04);
    oen = 1'b1;
    op(3'h7, 3'h0, 3'h1, 4'h0, 4'h0, 4'h8, 1'b0);
    chk({6'h0, y_oe, sg}, 8'h01);
    oen = 1'b0;
    // second reset in mid-run clears the file
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    op(3'h4, 3'h3, 3'h1, 4'h1, 4'h0, 4'h0, 1'b0);
    idle();
    chk({4'h0, y}, 8'h00);
    results();
  end
endmodule : fbs_slice_top_bench
`default_nettype wire
